// >>> inc/sfr_window_regs.svh
// Offsets, field positions, reset values and counts of the windowed register bank
`ifndef SFR_WINDOW_REGS_SVH
`define SFR_WINDOW_REGS_SVH
`define OFS_ZERO_LO 5'h00
`define OFS_ZERO_HI 5'h01
`define OFS_CONV_TIMING 5'h03
`define OFS_XSEL_LO 5'h04
`define OFS_XSEL_HI 5'h05
`define OFS_XSRV_LO 5'h06
`define OFS_XSRV_HI 5'h07
`define OFS_IRQ_PEND_LO 5'h08
`define OFS_IRQ_EN_LO 5'h09
`define OFS_IO_CTRL2 5'h0b
`define OFS_IO_CTRL3 5'h0c
`define OFS_IRQ_PEND_HI 5'h12
`define OFS_IRQ_EN_HI 5'h13
`define OFS_WINDOW_SEL 5'h14
`define OFS_PULSE1 5'h16
`define OFS_PULSE2 5'h17
`define WINDOW_BYTES 5'h18
`define WIN_NUM_0 8'h00
`define WIN_NUM_1 8'h01
`define WIN_NUM_15 8'h0f
`define CTRL2_CAM_FLUSH 7
`define CTRL2_LOCK_ALLOW 6
`define CTRL2_BOUNDARY 5
`define CTRL2_AD_FAST 4
`define CTRL2_TIMING_SRC 3
`define CTRL2_SLOW_PWM 2
`define CTRL2_UPDOWN 1
`define CTRL2_PER_STATE 0
`define CTRL2_RESET 8'h00
`define CTRL3_RESET 8'hf0
`define BYTE_RESET 8'h00
`define RESERVED_READ 8'hff
`define ZERO_BYTE 8'h00
`define IRQ_T2OVF_BIT 4
`define T2_MID_LO 16'h7fff
`define T2_MID_HI 16'h8000
`define T2_TOP 16'hffff
`define T2_BOTTOM 16'h0000
`define AD_FROM_REG 12'h000
`define T2_SLOW_DIV 3'h7
`define AD_CONV_PRESCALED 12'd1565
`define AD_CONV_DIRECT 12'd895
`define PWM_PERIOD_DIRECT 10'd256
`define PWM_PERIOD_SLOW 10'd512
`endif

// >>> inc/sfr_window_pkg.sv
// Types shared by the windowed register bank
package sfr_window_pkg;
	typedef logic [7:0] byte_t;
	typedef logic [4:0] sfr_addr_t;
	typedef enum logic [1:0] {
		WIN_ZERO = 2'b00,
		WIN_ONE = 2'b01,
		WIN_FIFTEEN = 2'b10
	} window_t;
endpackage : sfr_window_pkg

// >>> hw/sfr_window_and_io_control.sv
// Windowed special-register bank with the second I/O control register
// Functional notes
// - A selectable 24-byte block replaces the lowest 24 bytes of the lower register file.
// - Exactly three windows exist, numbered 0, 1 and 15; 1 and 15 have their own registers, 0 passes to the base file.
// - The register reached at a windowed address depends on the current window number.
// - Writing a window number to byte address 14h switches the active mapping.
// - Window 1 holds zero word, conversion timing, transfer words, irq regs, I/O control 3 etc.
// - Writing one to control bit 7 clears every CAM entry, locked ones included.
// - The CAM clear bit is not stored and reads back as one in window 15.
// - Bit 6 enables command locking, letting command bit 7 keep a command in the CAM.
// - Bit 5 picks the timer 2 overflow boundary: FFFFh/0000h when 0, 7FFFh/8000h when 1.
// - The timer 2 overflow interrupt is delivered only while high enable bit 4 is set.
// - In compatible mode bit 4 low gives 156.5-state conversion, high gives 89.5 states.
// - While bit 3 is set the A/D prescaler bit 4 is ignored.
// - Bit 3 low uses compatible A/D timing, high uses the conversion timing register.
// - Bit 2 selects a shared PWM prescaler: 256-state period at 0, 512-state at 1.
// - Bit 1 low counts timer 2 up only, high counts up on port pin low and down on high.
// - Bit 0 low increments timer 2 every eight states, high every state without reset.
`timescale 1ns/100ps
`default_nettype none
`include "sfr_window_regs.svh"

module sfr_window_and_io_control (
	input wire logic clk_sys,
	input wire logic rst_b,
	input wire logic sfr_sel,
	input wire logic sfr_wr,
	input wire logic sfr_rd,
	input wire sfr_window_pkg::sfr_addr_t sfr_addr,
	input wire sfr_window_pkg::byte_t sfr_wdata,
	input wire sfr_window_pkg::byte_t base_rdata,
	input wire logic state_tick,
	input wire logic updown_pin,
	input wire logic t2_reset_req,
	input wire logic t2_ovf_pend_clr,
	output sfr_window_pkg::byte_t sfr_rdata,
	output logic sfr_rdata_hit,
	output logic base_wr,
	output logic cam_flush,
	output logic cam_lock_allow,
	output logic [15:0] timer2_count,
	output logic timer2_is_reference,
	output logic t2_ovf_pending,
	output logic t2_ovf_irq,
	output logic [11:0] ad_conv_half_states,
	output logic ad_use_timing_reg,
	output logic [9:0] pwm_period_states,
	output sfr_window_pkg::byte_t conv_timing,
	output sfr_window_pkg::byte_t io_control_third
);
	import sfr_window_pkg::*;

	window_t register_window_q, register_window_d;
	byte_t window_select_q, window_select_d;
	byte_t io_control_second_q, io_control_second_d;
	byte_t conv_timing_q, conv_timing_d;
	byte_t xsel_lo_q, xsel_lo_d, xsel_hi_q, xsel_hi_d;
	byte_t xsrv_lo_q, xsrv_lo_d, xsrv_hi_q, xsrv_hi_d;
	byte_t pend_lo_q, pend_lo_d, en_lo_q, en_lo_d;
	byte_t pend_hi_q, pend_hi_d, en_hi_q, en_hi_d;
	byte_t io_control_third_q, io_control_third_d;
	byte_t pulse1_q, pulse1_d, pulse2_q, pulse2_d;
	byte_t rdata_q, rdata_d;
	logic hit_q, hit_d, base_wr_q, base_wr_d, flush_q, flush_d;
	logic [15:0] t2_q, t2_d;
	logic [2:0] t2_div_q, t2_div_d;
	logic irq_q, irq_d;
	logic [11:0] ad_q, ad_d;
	logic [9:0] pwm_q, pwm_d;
	logic ref_q, ref_d;
	logic in_window, wr1, wr15, win1;
	logic t2_step, t2_cross;
	logic [15:0] t2_next;

	// Windowed address decode
	assign in_window = sfr_sel && (sfr_addr < `WINDOW_BYTES);
	assign win1 = (register_window_q == WIN_ONE);
	assign wr1 = in_window && sfr_wr && win1;
	assign wr15 = in_window && sfr_wr && (register_window_q == WIN_FIFTEEN);

	// Window selection and register writes
	always_comb begin
		window_select_d = window_select_q;
		register_window_d = register_window_q;
		io_control_second_d = io_control_second_q;
		conv_timing_d = conv_timing_q;
		xsel_lo_d = xsel_lo_q;
		xsel_hi_d = xsel_hi_q;
		xsrv_lo_d = xsrv_lo_q;
		xsrv_hi_d = xsrv_hi_q;
		pend_lo_d = pend_lo_q;
		en_lo_d = en_lo_q;
		pend_hi_d = pend_hi_q;
		en_hi_d = en_hi_q;
		io_control_third_d = io_control_third_q;
		pulse1_d = pulse1_q;
		pulse2_d = pulse2_q;
		flush_d = 1'b0;
		// Window select lives at 14h in every window
		if (in_window && sfr_wr && sfr_addr == `OFS_WINDOW_SEL) begin
			window_select_d = sfr_wdata;
			case (sfr_wdata)
				`WIN_NUM_1: register_window_d = WIN_ONE;
				`WIN_NUM_15: register_window_d = WIN_FIFTEEN;
				default: register_window_d = WIN_ZERO;
			endcase
		end
		if (wr15 && sfr_addr == `OFS_IO_CTRL2) begin
			io_control_second_d = sfr_wdata;
			io_control_second_d[`CTRL2_CAM_FLUSH] = 1'b0;
			flush_d = sfr_wdata[`CTRL2_CAM_FLUSH];
		end
		// Window 1 set; other offsets fall through as reserved
		if (wr1) begin
			case (sfr_addr)
				`OFS_CONV_TIMING: conv_timing_d = sfr_wdata;
				`OFS_XSEL_LO: xsel_lo_d = sfr_wdata;
				`OFS_XSEL_HI: xsel_hi_d = sfr_wdata;
				`OFS_XSRV_LO: xsrv_lo_d = sfr_wdata;
				`OFS_XSRV_HI: xsrv_hi_d = sfr_wdata;
				`OFS_IRQ_PEND_LO: pend_lo_d = sfr_wdata;
				`OFS_IRQ_EN_LO: en_lo_d = sfr_wdata;
				`OFS_IO_CTRL3: io_control_third_d = sfr_wdata;
				`OFS_IRQ_PEND_HI: pend_hi_d = sfr_wdata;
				`OFS_IRQ_EN_HI: en_hi_d = sfr_wdata;
				`OFS_PULSE1: pulse1_d = sfr_wdata;
				`OFS_PULSE2: pulse2_d = sfr_wdata;
				default: pend_hi_d = pend_hi_d;
			endcase
		end
		// Overflow sets pending; set wins over a clear in the same cycle
		if (t2_ovf_pend_clr) begin
			pend_hi_d[`IRQ_T2OVF_BIT] = 1'b0;
		end
		if (t2_cross) begin
			pend_hi_d[`IRQ_T2OVF_BIT] = 1'b1;
		end
	end

	always_ff @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			window_select_q <= `BYTE_RESET;
			register_window_q <= WIN_ZERO;
			io_control_second_q <= `CTRL2_RESET;
			conv_timing_q <= `BYTE_RESET;
			xsel_lo_q <= `BYTE_RESET;
			xsel_hi_q <= `BYTE_RESET;
			xsrv_lo_q <= `BYTE_RESET;
			xsrv_hi_q <= `BYTE_RESET;
			pend_lo_q <= `BYTE_RESET;
			en_lo_q <= `BYTE_RESET;
			pend_hi_q <= `BYTE_RESET;
			en_hi_q <= `BYTE_RESET;
			io_control_third_q <= `CTRL3_RESET;
			pulse1_q <= `BYTE_RESET;
			pulse2_q <= `BYTE_RESET;
			flush_q <= 1'b0;
		end else begin
			window_select_q <= window_select_d;
			register_window_q <= register_window_d;
			io_control_second_q <= io_control_second_d;
			conv_timing_q <= conv_timing_d;
			xsel_lo_q <= xsel_lo_d;
			xsel_hi_q <= xsel_hi_d;
			xsrv_lo_q <= xsrv_lo_d;
			xsrv_hi_q <= xsrv_hi_d;
			pend_lo_q <= pend_lo_d;
			en_lo_q <= en_lo_d;
			pend_hi_q <= pend_hi_d;
			en_hi_q <= en_hi_d;
			io_control_third_q <= io_control_third_d;
			pulse1_q <= pulse1_d;
			pulse2_q <= pulse2_d;
			flush_q <= flush_d;
		end
	end

	// Read mux: window 1 set, window 15 control, else base file
	always_comb begin
		rdata_d = rdata_q;
		hit_d = 1'b0;
		base_wr_d = sfr_sel && sfr_wr && !(in_window && register_window_q != WIN_ZERO);
		if (sfr_sel && sfr_rd) begin
			hit_d = 1'b1;
			rdata_d = base_rdata;
			if (in_window && win1) begin
				case (sfr_addr)
					`OFS_ZERO_LO: rdata_d = `ZERO_BYTE;
					`OFS_ZERO_HI: rdata_d = `ZERO_BYTE;
					`OFS_CONV_TIMING: rdata_d = conv_timing_q;
					`OFS_XSEL_LO: rdata_d = xsel_lo_q;
					`OFS_XSEL_HI: rdata_d = xsel_hi_q;
					`OFS_XSRV_LO: rdata_d = xsrv_lo_q;
					`OFS_XSRV_HI: rdata_d = xsrv_hi_q;
					`OFS_IRQ_PEND_LO: rdata_d = pend_lo_q;
					`OFS_IRQ_EN_LO: rdata_d = en_lo_q;
					`OFS_IO_CTRL3: rdata_d = io_control_third_q;
					`OFS_IRQ_PEND_HI: rdata_d = pend_hi_q;
					`OFS_IRQ_EN_HI: rdata_d = en_hi_q;
					`OFS_WINDOW_SEL: rdata_d = window_select_q;
					`OFS_PULSE1: rdata_d = pulse1_q;
					`OFS_PULSE2: rdata_d = pulse2_q;
					default: rdata_d = `RESERVED_READ;
				endcase
			end else if (in_window && register_window_q == WIN_FIFTEEN) begin
				if (sfr_addr == `OFS_IO_CTRL2) begin
					rdata_d = io_control_second_q;
					rdata_d[`CTRL2_CAM_FLUSH] = 1'b1;
				end else if (sfr_addr == `OFS_WINDOW_SEL) begin
					rdata_d = window_select_q;
				end
			end else if (in_window && sfr_addr == `OFS_WINDOW_SEL) begin
				rdata_d = window_select_q;
			end
		end
	end

	always_ff @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			rdata_q <= `BYTE_RESET;
			hit_q <= 1'b0;
			base_wr_q <= 1'b0;
		end else begin
			rdata_q <= rdata_d;
			hit_q <= hit_d;
			base_wr_q <= base_wr_d;
		end
	end

	// Timer 2 stepping, direction and overflow boundary
	assign t2_step = state_tick && (io_control_second_q[`CTRL2_PER_STATE] ||
		t2_div_q == `T2_SLOW_DIV);
	assign t2_next = (io_control_second_q[`CTRL2_UPDOWN] && updown_pin) ?
		t2_q - 16'h0001 : t2_q + 16'h0001;
	// Exact value pairs; the mid pair must not flag in full-range mode
	assign t2_cross = t2_step && (io_control_second_q[`CTRL2_BOUNDARY] ?
		((t2_q == `T2_MID_LO && t2_next == `T2_MID_HI) ||
		(t2_q == `T2_MID_HI && t2_next == `T2_MID_LO)) :
		((t2_q == `T2_TOP && t2_next == `T2_BOTTOM) ||
		(t2_q == `T2_BOTTOM && t2_next == `T2_TOP)));
	always_comb begin
		t2_d = t2_q;
		t2_div_d = t2_div_q;
		if (state_tick) begin
			t2_div_d = t2_div_q + 3'h1;
		end
		if (t2_reset_req && !io_control_second_q[`CTRL2_PER_STATE]) begin
			t2_d = `T2_BOTTOM;
		end else if (t2_step) begin
			t2_d = t2_next;
		end
		ref_d = !io_control_second_q[`CTRL2_PER_STATE];
		irq_d = pend_hi_q[`IRQ_T2OVF_BIT] && en_hi_q[`IRQ_T2OVF_BIT];
		if (io_control_second_q[`CTRL2_TIMING_SRC]) begin
			ad_d = `AD_FROM_REG;
		end else begin
			ad_d = io_control_second_q[`CTRL2_AD_FAST] ? `AD_CONV_DIRECT : `AD_CONV_PRESCALED;
		end
		pwm_d = io_control_second_q[`CTRL2_SLOW_PWM] ? `PWM_PERIOD_SLOW : `PWM_PERIOD_DIRECT;
	end

	always_ff @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			t2_q <= `T2_BOTTOM;
			t2_div_q <= 3'h0;
			irq_q <= 1'b0;
			ad_q <= `AD_CONV_PRESCALED;
			pwm_q <= `PWM_PERIOD_DIRECT;
			ref_q <= 1'b1;
		end else begin
			t2_q <= t2_d;
			t2_div_q <= t2_div_d;
			irq_q <= irq_d;
			ad_q <= ad_d;
			pwm_q <= pwm_d;
			ref_q <= ref_d;
		end
	end

	// Outputs straight from flops
	assign sfr_rdata = rdata_q;
	assign sfr_rdata_hit = hit_q;
	assign base_wr = base_wr_q;
	assign cam_flush = flush_q;
	assign cam_lock_allow = io_control_second_q[`CTRL2_LOCK_ALLOW];
	assign timer2_count = t2_q;
	assign timer2_is_reference = ref_q;
	assign t2_ovf_pending = pend_hi_q[`IRQ_T2OVF_BIT];
	assign t2_ovf_irq = irq_q;
	assign ad_conv_half_states = ad_q;
	assign ad_use_timing_reg = io_control_second_q[`CTRL2_TIMING_SRC];
	assign pwm_period_states = pwm_q;
	assign conv_timing = conv_timing_q;
	assign io_control_third = io_control_third_q;

	// Checks
	chk_flush_pulse: assert property (@(posedge clk_sys) disable iff (!rst_b)
		wr15 && sfr_addr == `OFS_IO_CTRL2 && sfr_wdata[`CTRL2_CAM_FLUSH] |=> cam_flush)
		else $error("cam flush not pulsed");
	chk_flush_unstored: assert property (@(posedge clk_sys) disable iff (!rst_b)
		!io_control_second_q[`CTRL2_CAM_FLUSH])
		else $error("flush bit stored");
	chk_win_switch: assert property (@(posedge clk_sys) disable iff (!rst_b)
		in_window && sfr_wr && sfr_addr == `OFS_WINDOW_SEL && sfr_wdata == `WIN_NUM_1
		|=> register_window_q == WIN_ONE)
		else $error("window not switched");
	chk_irq_gate: assert property (@(posedge clk_sys) disable iff (!rst_b)
		t2_ovf_irq |-> $past(en_hi_q[`IRQ_T2OVF_BIT]))
		else $error("irq without enable");
	chk_pwm_period: assert property (@(posedge clk_sys) disable iff (!rst_b)
		$stable(io_control_second_q) |=> pwm_period_states ==
		($past(io_control_second_q[`CTRL2_SLOW_PWM]) ? `PWM_PERIOD_SLOW : `PWM_PERIOD_DIRECT))
		else $error("pwm period wrong");
	chk_ad_ignore: assert property (@(posedge clk_sys) disable iff (!rst_b)
		io_control_second_q[`CTRL2_TIMING_SRC] |=> ad_conv_half_states == `AD_FROM_REG)
		else $error("prescaler bit not ignored");
	chk_zero_read: assert property (@(posedge clk_sys) disable iff (!rst_b)
		sfr_sel && sfr_rd && win1 && sfr_addr == `OFS_ZERO_LO |=> sfr_rdata == `ZERO_BYTE)
		else $error("zero word nonzero");
	chk_reserved_read: assert property (@(posedge clk_sys) disable iff (!rst_b)
		sfr_sel && sfr_rd && win1 && sfr_addr == 5'h0d |=> sfr_rdata == `RESERVED_READ)
		else $error("reserved read wrong");
	chk_ovf_sets: assert property (@(posedge clk_sys) disable iff (!rst_b)
		t2_cross |=> t2_ovf_pending)
		else $error("overflow not flagged");
endmodule : sfr_window_and_io_control
`default_nettype wire

// >>> sim/sfr_window_and_io_control_tb.sv
// Self-checking bench for the windowed register bank and its I/O control
`timescale 1ns/100ps
`default_nettype none
`include "sfr_window_regs.svh"

module sfr_window_and_io_control_tb;
	import sfr_window_pkg::*;

	logic clk_sys, rst_b, sfr_sel, sfr_wr, sfr_rd, state_tick, updown_pin;
	logic t2_reset_req, t2_ovf_pend_clr, sfr_rdata_hit, base_wr, cam_flush, cam_lock_allow;
	logic timer2_is_reference, t2_ovf_pending, t2_ovf_irq, ad_use_timing_reg;
	sfr_addr_t sfr_addr;
	byte_t sfr_wdata, base_rdata, sfr_rdata, conv_timing, io_control_third, rd_val;
	logic [15:0] timer2_count, t2_start;
	logic [11:0] ad_conv_half_states;
	logic [9:0] pwm_period_states;
	logic bw, fl, hit;
	int mismatches, total_checks;
	sfr_addr_t rw_list[12] = '{5'h03, 5'h04, 5'h05, 5'h06, 5'h07, 5'h08, 5'h09, 5'h0c,
		5'h12, 5'h13, 5'h16, 5'h17};
	sfr_addr_t rsv_list[9] = '{5'h02, 5'h0a, 5'h0b, 5'h0d, 5'h0e, 5'h0f, 5'h10, 5'h11, 5'h15};

	sfr_window_and_io_control i_dut (
		.clk_sys(clk_sys), .rst_b(rst_b), .sfr_sel(sfr_sel), .sfr_wr(sfr_wr),
		.sfr_rd(sfr_rd), .sfr_addr(sfr_addr), .sfr_wdata(sfr_wdata), .base_rdata(base_rdata),
		.state_tick(state_tick), .updown_pin(updown_pin), .t2_reset_req(t2_reset_req),
		.t2_ovf_pend_clr(t2_ovf_pend_clr), .sfr_rdata(sfr_rdata), .sfr_rdata_hit(sfr_rdata_hit),
		.base_wr(base_wr), .cam_flush(cam_flush), .cam_lock_allow(cam_lock_allow),
		.timer2_count(timer2_count), .timer2_is_reference(timer2_is_reference),
		.t2_ovf_pending(t2_ovf_pending), .t2_ovf_irq(t2_ovf_irq),
		.ad_conv_half_states(ad_conv_half_states), .ad_use_timing_reg(ad_use_timing_reg),
		.pwm_period_states(pwm_period_states), .conv_timing(conv_timing),
		.io_control_third(io_control_third)
	);

	// 200 MHz system clock
	initial begin
		clk_sys = 1'b0;
		forever #2.5 clk_sys = ~clk_sys;
	end

	// Compare seen against expected and count
	task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
		total_checks++;
		if (seen !== exp) begin
			mismatches++;
			$display("MISMATCH %s expected %h seen %h", what, exp, seen);
		end
	endtask : check

	// One write cycle; captures the pulses that answer it
	task automatic wr(input sfr_addr_t a, input byte_t d);
		@(posedge clk_sys);
		sfr_sel <= 1'b1;
		sfr_wr <= 1'b1;
		sfr_addr <= a;
		sfr_wdata <= d;
		@(posedge clk_sys);
		sfr_sel <= 1'b0;
		sfr_wr <= 1'b0;
		#1;
		bw = base_wr;
		fl = cam_flush;
	endtask : wr

	// One read cycle; data is taken with its hit pulse
	task automatic rd(input sfr_addr_t a);
		@(posedge clk_sys);
		sfr_sel <= 1'b1;
		sfr_rd <= 1'b1;
		sfr_addr <= a;
		@(posedge clk_sys);
		sfr_sel <= 1'b0;
		sfr_rd <= 1'b0;
		#1;
		rd_val = sfr_rdata;
		hit = sfr_rdata_hit;
	endtask : rd

	// Let registered side outputs catch up
	task automatic settle;
		repeat (2) @(posedge clk_sys);
		#1;
	endtask : settle

	task automatic give_verdict;
		$display("checks %0d mismatches %0d", total_checks, mismatches);
		if (mismatches == 0 && total_checks > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask : give_verdict

	// Watchdog sized well beyond the overflow wait
	initial begin
		repeat (60000) @(posedge clk_sys);
		mismatches++;
		give_verdict();
	end

	// Main sequence
	initial begin
		rst_b = 1'b0;
		{sfr_sel, sfr_wr, sfr_rd, state_tick, updown_pin, t2_reset_req, t2_ovf_pend_clr} = '0;
		sfr_addr = 5'h00;
		sfr_wdata = 8'h00;
		base_rdata = 8'h00;
		repeat (4) @(posedge clk_sys);
		rst_b <= 1'b1;
		settle();
		check("ctrl3 reset", io_control_third, `CTRL3_RESET);
		check("ad reset", ad_conv_half_states, `AD_CONV_PRESCALED);
		check("pwm reset", pwm_period_states, `PWM_PERIOD_DIRECT);
		check("lock reset", cam_lock_allow, 1'b0);
		check("t2 ref reset", timer2_is_reference, 1'b1);
		// Window 1: every register distinct, read back without aliasing
		wr(`OFS_WINDOW_SEL, `WIN_NUM_1);
		rd(`OFS_IO_CTRL3);
		check("w1 ctrl3", rd_val, `CTRL3_RESET);
		check("read hit", hit, 1'b1);
		foreach (rw_list[i]) wr(rw_list[i], {3'h0, rw_list[i]} ^ 8'ha5);
		check("w1 write to base", bw, 1'b0);
		foreach (rw_list[i]) begin
			rd(rw_list[i]);
			check("w1 reg", rd_val, {3'h0, rw_list[i]} ^ 8'ha5);
		end
		check("conv timing out", conv_timing, 8'ha6);
		check("ctrl3 out", io_control_third, 8'ha9);
		rd(`OFS_WINDOW_SEL);
		check("w1 window sel", rd_val, `WIN_NUM_1);
		wr(`OFS_ZERO_LO, 8'hff);
		wr(`OFS_ZERO_HI, 8'hff);
		rd(`OFS_ZERO_LO);
		check("zero lo", rd_val, `ZERO_BYTE);
		rd(`OFS_ZERO_HI);
		check("zero hi", rd_val, `ZERO_BYTE);
		foreach (rsv_list[i]) begin
			wr(rsv_list[i], 8'h55);
			rd(rsv_list[i]);
			check("w1 reserved", rd_val, `RESERVED_READ);
		end
		wr(5'h18, 8'h33);
		check("above window", bw, 1'b1);
		wr(`OFS_IRQ_PEND_HI, 8'h00);
		wr(`OFS_IRQ_EN_HI, 8'h00);
		// Window 15: second I/O control modes
		wr(`OFS_WINDOW_SEL, `WIN_NUM_15);
		wr(`OFS_IO_CTRL2, 8'hc4);
		check("cam flush", fl, 1'b1);
		settle();
		check("lock on", cam_lock_allow, 1'b1);
		check("pwm slow", pwm_period_states, `PWM_PERIOD_SLOW);
		rd(`OFS_IO_CTRL2);
		check("ctrl2 read", rd_val, 8'hc4);
		wr(`OFS_IO_CTRL2, 8'h10);
		check("no flush", fl, 1'b0);
		settle();
		check("ad fast", ad_conv_half_states, `AD_CONV_DIRECT);
		check("lock off", cam_lock_allow, 1'b0);
		rd(`OFS_IO_CTRL2);
		check("ctrl2 read flush", rd_val, 8'h90);
		wr(`OFS_IO_CTRL2, 8'h18);
		settle();
		check("ad timing reg", ad_conv_half_states, 12'd0);
		check("ad use reg", ad_use_timing_reg, 1'b1);
		// Normal timer mode: one step per eight ticks, then a reset request
		wr(`OFS_IO_CTRL2, 8'h00);
		@(posedge clk_sys);
		state_tick <= 1'b1;
		repeat (16) @(posedge clk_sys);
		state_tick <= 1'b0;
		settle();
		check("t2 slow count", timer2_count, 16'h0002);
		@(posedge clk_sys);
		t2_reset_req <= 1'b1;
		@(posedge clk_sys);
		t2_reset_req <= 1'b0;
		settle();
		check("t2 reset", timer2_count, 16'h0000);
		// Per-state count up to the mid boundary
		wr(`OFS_IO_CTRL2, 8'h21);
		@(posedge clk_sys);
		state_tick <= 1'b1;
		for (int n = 0; n < 40000 && timer2_count !== 16'h8000; n++) @(posedge clk_sys);
		settle();
		check("t2 ref off", timer2_is_reference, 1'b0);
		check("ovf pending", t2_ovf_pending, 1'b1);
		check("irq masked", t2_ovf_irq, 1'b0);
		wr(`OFS_WINDOW_SEL, `WIN_NUM_1);
		wr(`OFS_IRQ_EN_HI, 8'h10);
		settle();
		check("irq enabled", t2_ovf_irq, 1'b1);
		@(posedge clk_sys);
		t2_ovf_pend_clr <= 1'b1;
		@(posedge clk_sys);
		t2_ovf_pend_clr <= 1'b0;
		settle();
		check("pending cleared", t2_ovf_pending, 1'b0);
		// Up/down mode counting down while the pin is high
		wr(`OFS_WINDOW_SEL, `WIN_NUM_15);
		wr(`OFS_IO_CTRL2, 8'h03);
		@(posedge clk_sys);
		updown_pin <= 1'b1;
		settle();
		t2_start = timer2_count;
		repeat (4) @(posedge clk_sys);
		#1;
		check("t2 down", timer2_count, t2_start - 16'h0004);
		// Falling through the mid value must not flag in full-range mode
		for (int n = 0; n < 400 && timer2_count !== 16'h7ff0; n++) begin
			@(posedge clk_sys);
			#1;
		end
		check("t2 below mid", timer2_count, 16'h7ff0);
		check("mid ignored", t2_ovf_pending, 1'b0);
		@(posedge clk_sys);
		state_tick <= 1'b0;
		// Window 0: accesses pass to the base file
		wr(`OFS_WINDOW_SEL, `WIN_NUM_0);
		wr(`OFS_IO_CTRL3, 8'h11);
		check("w0 write base", bw, 1'b1);
		check("ctrl3 kept", io_control_third, 8'ha9);
		@(posedge clk_sys);
		base_rdata <= 8'h3c;
		rd(`OFS_IO_CTRL3);
		check("w0 read base", rd_val, 8'h3c);
		give_verdict();
	end
endmodule : sfr_window_and_io_control_tb
`default_nettype wire
